// ---- rtl/octal_conv_pkg.sv ----
package octal_conv_pkg;
    // Frame layout
    localparam int          FRAME_BITS      = 24;
    localparam int          ADDR_HI         = 23;
    localparam int          ADDR_LO         = 16;
    localparam int          DATA_HI         = 15;
    localparam int          CODE_HI         = 11;
    localparam int          CODE_LO         = 2;
    localparam int          CODE_W          = 10;
    localparam int          NUM_CH          = 8;
    localparam int          CNT_W           = 5;
    // Register addresses
    localparam logic [7:0]  ADDR_SETUP      = 8'h01;
    localparam logic [7:0]  ADDR_TRIGGER    = 8'h02;
    localparam logic [7:0]  ADDR_BROADCAST  = 8'h03;
    localparam logic [7:0]  ADDR_CH_FIRST   = 8'h08;
    localparam logic [7:0]  ADDR_CH_LAST    = 8'h0f;
    // Setup register fields
    localparam int          GLOBAL_PD_BIT   = 8;
    localparam logic [7:0]  CH_PD_RESET     = 8'hff;
    // Trigger register fields
    localparam int          SOFT_RST_HI     = 3;
    localparam logic [3:0]  SOFT_RST_CODE   = 4'ha;
    // Power-up wait the host must respect
    localparam int          POWERUP_WAIT_MS = 5;
endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ns
// Two-stage synchroniser for one level
module pin_sync
    import octal_conv_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level
    input  wire logic din,
    output logic      dout
);
    logic meta;
    logic next_meta;
    logic next_dout;

    // First stage feeds only the second
    always_comb begin
        next_meta = din;
        next_dout = meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule // pin_sync

// ---- rtl/octal_conv_ctrl.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Frame starts at select low; device acts only at select rising edge.
// - Data input is sampled on each falling serial clock while selected.
// - Frames under 24 falling edges are discarded, nothing changes.
// - Bits after the first 24 of a frame are ignored.
// - Bits 23..16 sent first are address; bits 15..0 are data.
// - Works with continuous or gated serial clock.
// - Link is write-only; no readback and no serial output.
// - Channel writes land in buffer; outputs follow separate active register.
// - Load low before write: active updated at end of frame.
// - Load high before write: active holds; all transfer when load goes low.
// - Clear low forces all buffer and active codes to zero on the clock, after the pin synchroniser.
// - After power-on or any reset all channel codes are zero.
// - Soft reset code 1010 returns all registers to defaults.
// - Amplifiers power down individually or globally via setup register.
// - Channels start powered down until host writes zero to their bit.
// - Setup bit 8 global power-down; bits 7..0 per channel, reset all ones.
// - Broadcast write loads code into every channel; code in bits 11..2.
// - Soft reset field is bits 3..0; other values have no effect.
module octal_conv_ctrl
    import octal_conv_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Serial link pins
    input  wire logic                     frame_sel_n,
    input  wire logic                     serial_clk,
    input  wire logic                     serial_din,
    // Control pins
    input  wire logic                     load_update_n,
    input  wire logic                     clear_outputs_n,
    // Converter side
    output logic [NUM_CH*CODE_W-1:0]      active_codes,
    output logic [NUM_CH-1:0]             channel_powerdown,
    output logic                          global_powerdown
);
    // Synchronised pins
    logic sel_n_s;
    logic sclk_s;
    logic din_s;
    logic load_update_n_s;
    logic clr_s;

    pin_sync #(.RESET_VAL(1'b1)) u_sync_sel  (.clk(clk), .rst(rst), .din(frame_sel_n),
                                              .dout(sel_n_s));
    pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk (.clk(clk), .rst(rst), .din(serial_clk),
                                              .dout(sclk_s));
    pin_sync #(.RESET_VAL(1'b0)) u_sync_din  (.clk(clk), .rst(rst), .din(serial_din),
                                              .dout(din_s));
    pin_sync #(.RESET_VAL(1'b1)) u_sync_load_update_n (.clk(clk), .rst(rst), .din(load_update_n),
                                              .dout(load_update_n_s));
    pin_sync #(.RESET_VAL(1'b1)) u_sync_clr  (.clk(clk), .rst(rst), .din(clear_outputs_n),
                                              .dout(clr_s));

    // Edge history of synchronised levels
    logic sclk_d;
    logic sel_n_d;
    logic load_update_n_d;
    logic sclk_fall;
    logic sel_rise;
    logic load_update_n_fall;

    // Serial capture state
    logic [FRAME_BITS-1:0] shreg;
    logic [CNT_W-1:0]      bit_cnt;
    logic                  load_update_n_at_start;
    logic [FRAME_BITS-1:0] next_shreg;
    logic [CNT_W-1:0]      next_bit_cnt;
    logic                  next_load_update_n_at_start;

    // Register state
    logic [CODE_W-1:0] buf_code [NUM_CH];
    logic [CODE_W-1:0] act_code [NUM_CH];
    logic [CODE_W-1:0] next_buf [NUM_CH];
    logic [CODE_W-1:0] next_act [NUM_CH];
    logic [NUM_CH-1:0] next_ch_pd;
    logic              next_glob_pd;

    // Frame decode
    logic              frame_ok;
    logic [7:0]        f_addr;
    logic [CODE_W-1:0] f_code;

    // Edges are seen only through the sampled clock, so a gated clock is fine
    assign sclk_fall = sclk_d & ~sclk_s;
    assign sel_rise  = ~sel_n_d & sel_n_s;
    assign load_update_n_fall = load_update_n_d & ~load_update_n_s;

    // Serial shift and bit count
    always_comb begin
        next_shreg         = shreg;
        next_bit_cnt       = bit_cnt;
        next_load_update_n_at_start = load_update_n_at_start;
        if (sel_n_s) begin
            next_bit_cnt = '0;
            // Load pin level captured before the write completes
            next_load_update_n_at_start = load_update_n_s;
        end else if (sclk_fall && bit_cnt < CNT_W'(FRAME_BITS)) begin
            next_shreg   = {shreg[FRAME_BITS-2:0], din_s};
            next_bit_cnt = bit_cnt + 1'b1;
        end
    end

    assign frame_ok = sel_rise && (bit_cnt == CNT_W'(FRAME_BITS));
    assign f_addr   = shreg[ADDR_HI:ADDR_LO];
    assign f_code   = shreg[CODE_HI:CODE_LO];

    // Register update on completed frame and load pin
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            next_buf[i] = buf_code[i];
            next_act[i] = act_code[i];
        end
        next_ch_pd   = channel_powerdown;
        next_glob_pd = global_powerdown;
        // Load falling edge moves all buffers to active together
        if (load_update_n_fall) begin
            for (int i = 0; i < NUM_CH; i++) next_act[i] = buf_code[i];
        end
        if (frame_ok) begin
            if (f_addr == ADDR_SETUP) begin
                next_ch_pd   = shreg[NUM_CH-1:0];
                next_glob_pd = shreg[GLOBAL_PD_BIT];
            end else if (f_addr == ADDR_TRIGGER) begin
                if (shreg[SOFT_RST_HI:0] == SOFT_RST_CODE) begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        next_buf[i] = '0;
                        next_act[i] = '0;
                    end
                    next_ch_pd   = CH_PD_RESET;
                    next_glob_pd = 1'b0;
                end
            end else if (f_addr == ADDR_BROADCAST) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    next_buf[i] = f_code;
                    next_act[i] = f_code;
                end
            end else if (f_addr >= ADDR_CH_FIRST && f_addr <= ADDR_CH_LAST) begin
                next_buf[f_addr[2:0]] = f_code;
                if (!load_update_n_at_start) begin
                    next_act[f_addr[2:0]] = f_code;
                end
            end
        end
        // Clear beats any code write or load edge in the same cycle; a setup frame's power-down update still lands
        if (!clr_s) begin
            for (int i = 0; i < NUM_CH; i++) begin
                next_buf[i] = '0;
                next_act[i] = '0;
            end
        end
    end

    // Edge history and serial state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d        <= 1'b0;
            sel_n_d       <= 1'b1;
            load_update_n_d        <= 1'b1;
            shreg         <= '0;
            bit_cnt       <= '0;
            load_update_n_at_start <= 1'b1;
        end else begin
            sclk_d        <= sclk_s;
            sel_n_d       <= sel_n_s;
            load_update_n_d        <= load_update_n_s;
            shreg         <= next_shreg;
            bit_cnt       <= next_bit_cnt;
            load_update_n_at_start <= next_load_update_n_at_start;
        end
    end

    // Power-down state; clear leaves it alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_powerdown <= CH_PD_RESET;
            global_powerdown  <= 1'b0;
        end else begin
            channel_powerdown <= next_ch_pd;
            global_powerdown  <= next_glob_pd;
        end
    end

    // Channel codes; clear is folded into the next values above
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                buf_code[i] <= '0;
                act_code[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                buf_code[i] <= next_buf[i];
                act_code[i] <= next_act[i];
            end
        end
    end

    // Outputs follow active registers only; no serial output exists
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            active_codes[i*CODE_W +: CODE_W] = act_code[i];
        end
    end

    // Checks
    a_short_frame_drop: assert property (@(posedge clk) disable iff (rst)
        (sel_rise && bit_cnt != CNT_W'(FRAME_BITS) && !load_update_n_fall && clr_s)
        |=> $stable(active_codes) && $stable(channel_powerdown))
        else $error("short frame changed state");
    a_count_cap: assert property (@(posedge clk) disable iff (rst)
        bit_cnt <= CNT_W'(FRAME_BITS)) else $error("bit count overran");
    a_count_idle: assert property (@(posedge clk) disable iff (rst)
        sel_n_s |=> bit_cnt == '0) else $error("count not cleared");
    a_clear_zero: assert property (@(posedge clk) disable iff (rst)
        !clr_s |=> active_codes == '0) else $error("clear did not zero");
    a_load_copy: assert property (@(posedge clk) disable iff (rst)
        (load_update_n_fall && clr_s && !frame_ok)
        |=> act_code[0] == $past(buf_code[0])) else $error("load transfer missed");
    a_setup_write: assert property (@(posedge clk) disable iff (rst)
        (frame_ok && f_addr == ADDR_SETUP)
        |=> channel_powerdown == $past(shreg[NUM_CH-1:0])) else $error("setup not taken");
    a_soft_reset: assert property (@(posedge clk) disable iff (rst)
        (frame_ok && f_addr == ADDR_TRIGGER && shreg[SOFT_RST_HI:0] == SOFT_RST_CODE)
        |=> channel_powerdown == CH_PD_RESET && active_codes == '0)
        else $error("soft reset failed");
    a_async_update: assert property (@(posedge clk) disable iff (rst)
        (frame_ok && f_addr == ADDR_CH_FIRST && !load_update_n_at_start && clr_s)
        |=> act_code[0] == $past(f_code)) else $error("immediate update missed");
endmodule // octal_conv_ctrl

// ---- dv/host_model.sv ----
`timescale 1ns/1ns
// Serial master in the host's place; its link clock is gated outside frames
module host_model
    import octal_conv_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Link pins
    output logic      frame_sel_n,
    output logic      serial_clk,
    output logic      serial_din
);
    // Idle link at time zero
    initial begin
        frame_sel_n = 1'b1;
        serial_clk  = 1'b0;
        serial_din  = 1'b0;
    end

    // Send n falling edges: the word MSB first, then toggling filler bits
    task automatic send(input logic [23:0] w, input int n);
        logic b;
        frame_sel_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            b = (i < FRAME_BITS) ? w[ADDR_HI - i] : ~b;
            serial_din <= b;
            serial_clk <= 1'b1;
            repeat (4) @(posedge clk);
            serial_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        frame_sel_n <= 1'b1;
        serial_din  <= ~b; // Released line must not keep the last bit
        repeat (8) @(posedge clk);
    endtask
endmodule // host_model

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb
    import octal_conv_pkg::*;
;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   frame_sel_n;
    logic                   serial_clk;
    logic                   serial_din;
    logic                   load_update_n = 1'b1;
    logic                   clear_outputs_n = 1'b1;
    logic [NUM_CH*CODE_W-1:0] active_codes;
    logic [NUM_CH-1:0]      channel_powerdown;
    logic                   global_powerdown;
    int                     mismatches = 0;
    int                     n_tests = 0;
    int                     cycles = 0;

    // Clock of 100 ns
    always #50 clk = ~clk;

    octal_conv_ctrl dut_u (.clk(clk), .rst(rst), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .serial_din(serial_din), .load_update_n(load_update_n),
        .clear_outputs_n(clear_outputs_n), .active_codes(active_codes),
        .channel_powerdown(channel_powerdown), .global_powerdown(global_powerdown));
    host_model host_u (.clk(clk), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
        .serial_din(serial_din));

    function automatic logic [CODE_W-1:0] ch(input int i);
        return active_codes[i*CODE_W +: CODE_W];
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Hang guard: the power-up wait dominates the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            end_of_test();
        end
    end

    // Load pulse well past the minimum low time
    task automatic pulse_load();
        load_update_n <= 1'b0;
        repeat (4) @(posedge clk);
        load_update_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_reset();
        `CHK("codes", 80'h0, active_codes)
        `CHK("ch_pd", CH_PD_RESET, channel_powerdown)
        `CHK("glob_pd", 1'b0, global_powerdown)
        $display("test reset done");
    endtask

    task automatic t_async();
        load_update_n <= 1'b0;
        repeat (4) @(posedge clk);
        host_u.send({ADDR_CH_FIRST, 16'h0ffc}, 24);
        `CHK("ch0", 10'h3ff, ch(0))
        load_update_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("test async done");
    endtask

    task automatic t_sync();
        host_u.send({8'h09, 16'h0554}, 24);
        `CHK("ch1 held", 10'h000, ch(1))
        pulse_load();
        `CHK("ch1", 10'h155, ch(1))
        $display("test sync done");
    endtask

    task automatic t_frames();
        load_update_n <= 1'b0;
        repeat (4) @(posedge clk);
        host_u.send({8'h0a, 16'h0804}, 23);
        `CHK("ch2 short", 10'h000, ch(2))
        host_u.send({8'h0a, 16'h0804}, 30);
        `CHK("ch2 long", 10'h201, ch(2))
        `CHK("ch0 kept", 10'h3ff, ch(0))
        load_update_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("test frames done");
    endtask

    task automatic t_bcast();
        host_u.send({ADDR_BROADCAST, 16'h0a5c}, 24);
        for (int i = 0; i < NUM_CH; i++) `CHK("bcast", 10'h297, ch(i))
        $display("test broadcast done");
    endtask

    task automatic t_setup();
        host_u.send({ADDR_SETUP, 16'h015a}, 24);
        `CHK("ch_pd", 8'h5a, channel_powerdown)
        `CHK("glob_pd", 1'b1, global_powerdown)
        host_u.send({ADDR_SETUP, 16'h0100}, 24);
        `CHK("ch_pd up", 8'h00, channel_powerdown)
        `CHK("glob_pd kept", 1'b1, global_powerdown)
        $display("test setup done");
    endtask

    task automatic t_clear();
        clear_outputs_n <= 1'b0;
        repeat (4) @(posedge clk);
        clear_outputs_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("cleared", 80'h0, active_codes)
        `CHK("pd kept", 8'h00, channel_powerdown)
        // A load pulse exposes any buffer the clear missed
        pulse_load();
        `CHK("buf cleared", 80'h0, active_codes)
        $display("test clear done");
    endtask

    task automatic t_soft();
        host_u.send({ADDR_BROADCAST, 16'h0ffc}, 24);
        host_u.send({ADDR_TRIGGER, 16'h0005}, 24);
        `CHK("ch3 kept", 10'h3ff, ch(3))
        host_u.send({ADDR_TRIGGER, 16'h000a}, 24);
        `CHK("codes", 80'h0, active_codes)
        `CHK("ch_pd", CH_PD_RESET, channel_powerdown)
        `CHK("glob_pd", 1'b0, global_powerdown)
        $display("test soft reset done");
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (POWERUP_WAIT_MS * 10000) @(posedge clk);
        t_reset();
        t_async();
        t_sync();
        t_frames();
        t_bcast();
        t_setup();
        t_clear();
        t_soft();
        end_of_test();
    end
endmodule // tb
